// ==== idd_core.v ====
// Summary of operation
// - Packing on: first five transmit frames are zero, host data on sixth.
// - Packing off: first three transmit frames are zero, host data on fourth.
// - 8-bit and 18-32 bit words: first two received frames read zero.
// - 10-16 bit words: first three received frames read zero.
// - Loopback, packed, 8-bit, divider 000: first data on seventh sample.
// - Loopback, packed, 8-bit, divider 001-101: first data on sixth sample.
// - Loopback, packed, 10-16 bit, divider 001: first data on fifth sample.
// - Loopback, packed, 10-16 bit, divider 010-101: data on fourth sample.
// - Loopback, unpacked, any length and divider: data on third sample.
`include "idd_defs.vh"
`default_nettype none

module idd_core #(
  parameter WORD_W = `IDD_WORD_W,
  parameter DEPTH  = `IDD_PIPE_DEPTH
) (
  input  wire              sys_clk,           // System clock, 50 MHz
  input  wire              resetn,            // Synchronous reset, low
  input  wire              clkEn,             // Freezes state while low
  input  wire              packEn,            // Word packing setting
  input  wire [3:0]        wordLen,           // Word length code
  input  wire [2:0]        frameSyncDivider,  // Frame-sync divider field
  input  wire              loopbackEn,        // Transmit fed back to receive
  input  wire [WORD_W-1:0] txData,            // Host transmit word
  input  wire              txValid,           // Host offers a word
  output wire              txReady,           // Room for a word
  output wire [WORD_W-1:0] rxData,            // Received word
  output wire              rxValid,           // One-cycle word strobe
  input  wire              bitClk,            // Link bit clock pin
  input  wire              frameSync,         // Link frame sync pin
  input  wire              serialDataIn,      // Link receive data pin
  output wire              serialDataOut      // Link transmit data pin
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  reg        bclkS1_ff, bclkS2_ff, bclkS3_ff;
  reg        fsS1_ff, fsS2_ff, fsLast_ff;
  reg        sdS1_ff, sdS2_ff;

  // Two stages per pin, three on the bit clock; its edge detector compares stages two and three
  always @(posedge sys_clk) begin
    if (!resetn) begin
      bclkS1_ff <= 1'b0;
      bclkS2_ff <= 1'b0;
      bclkS3_ff <= 1'b0;
      fsS1_ff   <= 1'b0;
      fsS2_ff   <= 1'b0;
      sdS1_ff   <= 1'b0;
      sdS2_ff   <= 1'b0;
    end else if (clkEn) begin
      bclkS1_ff <= bitClk;
      bclkS2_ff <= bclkS1_ff;
      bclkS3_ff <= bclkS2_ff;
      fsS1_ff   <= frameSync;
      fsS2_ff   <= fsS1_ff;
      sdS1_ff   <= serialDataIn;
      sdS2_ff   <= sdS1_ff;
    end
  end

  wire bitRise    = bclkS2_ff & ~bclkS3_ff;
  wire bitFall    = ~bclkS2_ff & bclkS3_ff;
  wire frameStart = bitRise & fsS2_ff & ~fsLast_ff;

  // Frame sync level as seen at the previous bit-clock rise
  always @(posedge sys_clk) begin
    if (!resetn) begin
      fsLast_ff <= 1'b0;
    end else if (clkEn && bitRise) begin
      fsLast_ff <= fsS2_ff;
    end
  end

  // ----------------------------------------------------------------
  // Latency selection
  // ----------------------------------------------------------------
  reg  [5:0] wordBits;
  reg  [2:0] txDly;
  reg  [2:0] rxDly;
  wire       midLen = (wordLen >= `IDD_WL_10) && (wordLen <= `IDD_WL_16);

  // Bits per word for each length code
  always @* begin
    case (wordLen)
      `IDD_WL_8:  wordBits = 6'h08;
      `IDD_WL_10: wordBits = 6'h0a;
      `IDD_WL_12: wordBits = 6'h0c;
      `IDD_WL_14: wordBits = 6'h0e;
      `IDD_WL_16: wordBits = 6'h10;
      `IDD_WL_18: wordBits = 6'h12;
      `IDD_WL_20: wordBits = 6'h14;
      `IDD_WL_24: wordBits = 6'h18;
      default:    wordBits = 6'h20;
    endcase
  end

  // In loopback the whole latency sits on the receive side, so the
  // count is to the first looped sample, not a sum of both paths
  always @* begin
    txDly = packEn ? `IDD_TX_DLY_PACK : `IDD_TX_DLY_NOPACK;
    rxDly = midLen ? `IDD_RX_DLY_LONG : `IDD_RX_DLY_SHORT;
    if (loopbackEn) begin
      txDly = 3'h0;
      if (!packEn) begin
        rxDly = `IDD_LB_DLY_NOPACK;
      end else if (wordLen == `IDD_WL_8) begin
        if (frameSyncDivider == `IDD_FSYNC_DIV_0) begin
          rxDly = `IDD_LB_DLY_8_DIV0;
        end else begin
          rxDly = `IDD_LB_DLY_8;
        end
      end else if (midLen) begin
        if (frameSyncDivider <= `IDD_FSYNC_DIV_1) begin
          rxDly = `IDD_LB_DLY_16_DIV1;
        end else begin
          rxDly = `IDD_LB_DLY_16;
        end
      end else begin
        rxDly = `IDD_LB_DLY_WIDE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  wire [WORD_W-1:0]       bufData;
  wire                    bufValid;
  wire                    bufPop = frameStart & clkEn;
  reg  [DEPTH*WORD_W-1:0] txPipe_ff;
  reg  [WORD_W-1:0]       txShift_ff;
  reg                     serialDataOut_ff;
  reg  [WORD_W-1:0]       txWord;
  wire [2:0]              txIdx = txDly - 3'h1;

  // Host words wait here so a late frame loses nothing
  idd_buf2 #(
    .WIDTH    (WORD_W)
  ) u_txBuf (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .inData   (txData),
    .inValid  (txValid),
    .inReady  (txReady),
    .outData  (bufData),
    .outValid (bufValid),
    .outReady (bufPop)
  );

  // An empty buffer at frame start sends a zero word (underrun)
  wire [WORD_W-1:0] popWord = bufValid ? bufData : {WORD_W{1'b0}};

  // Word leaving the pipeline this frame
  always @* begin
    if (txDly == 3'h0) begin
      txWord = popWord;
    end else begin
      txWord = txPipe_ff[txIdx*WORD_W +: WORD_W];
    end
  end

  // Pipeline clears to zero, so the first frames go out as zeros
  always @(posedge sys_clk) begin
    if (!resetn) begin
      txPipe_ff <= {DEPTH*WORD_W{1'b0}};
    end else if (clkEn && frameStart) begin
      txPipe_ff <= {txPipe_ff[(DEPTH-1)*WORD_W-1:0], popWord};
    end
  end

  // Left-justify on load, then MSB first on each falling edge; the
  // bits past the word length shift out as zeros
  always @(posedge sys_clk) begin
    if (!resetn) begin
      txShift_ff       <= {WORD_W{1'b0}};
      serialDataOut_ff <= 1'b0;
    end else if (clkEn) begin
      if (frameStart) begin
        txShift_ff <= txWord << (6'h20 - wordBits);
      end else if (bitFall) begin
        serialDataOut_ff <= txShift_ff[WORD_W-1];
        txShift_ff       <= {txShift_ff[WORD_W-2:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  reg  [WORD_W-1:0]       rxShift_ff;
  reg  [5:0]              rxCnt_ff;
  reg                     rxArmed_ff;
  reg  [DEPTH*WORD_W-1:0] rxPipe_ff;
  reg  [WORD_W-1:0]       rxData_ff;
  reg                     rxValid_ff;
  reg  [WORD_W-1:0]       rxWord;
  wire [2:0]              rxIdx = rxDly - 3'h1;
  wire                    rxBit = loopbackEn ? serialDataOut_ff : sdS2_ff;
  wire                    rxPush = frameStart & rxArmed_ff;

  // Word leaving the receive pipeline this frame
  always @* begin
    if (rxDly == 3'h0) begin
      rxWord = rxShift_ff;
    end else begin
      rxWord = rxPipe_ff[rxIdx*WORD_W +: WORD_W];
    end
  end

  // Bits gather right-justified; a frame closes at the next sync
  always @(posedge sys_clk) begin
    if (!resetn) begin
      rxShift_ff <= {WORD_W{1'b0}};
      rxCnt_ff   <= 6'h00;
      rxArmed_ff <= 1'b0;
    end else if (clkEn) begin
      if (frameStart) begin
        rxShift_ff <= {WORD_W{1'b0}};
        rxCnt_ff   <= 6'h00;
        rxArmed_ff <= 1'b1;
      end else if (bitRise && rxArmed_ff && rxCnt_ff < wordBits) begin
        rxShift_ff <= {rxShift_ff[WORD_W-2:0], rxBit};
        rxCnt_ff   <= rxCnt_ff + 6'h01;
      end
    end
  end

  // Zeros leave first; the consumer is expected to drop them
  always @(posedge sys_clk) begin
    if (!resetn) begin
      rxPipe_ff  <= {DEPTH*WORD_W{1'b0}};
      rxData_ff  <= {WORD_W{1'b0}};
      rxValid_ff <= 1'b0;
    end else if (clkEn) begin
      rxValid_ff <= rxPush;
      if (rxPush) begin
        rxPipe_ff <= {rxPipe_ff[(DEPTH-1)*WORD_W-1:0], rxShift_ff};
        rxData_ff <= rxWord;
      end
    end
  end

  assign rxData        = rxData_ff;
  assign rxValid       = rxValid_ff;
  assign serialDataOut = serialDataOut_ff;

endmodule // idd_core

`default_nettype wire

// ==== idd_defs.vh ====
`ifndef IDD_DEFS_VH
`define IDD_DEFS_VH

// ----------------------------------------------------------------
// Word length codes
// ----------------------------------------------------------------
`define IDD_WL_8            4'h0
`define IDD_WL_10           4'h1
`define IDD_WL_12           4'h2
`define IDD_WL_14           4'h3
`define IDD_WL_16           4'h4
`define IDD_WL_18           4'h5
`define IDD_WL_20           4'h6
`define IDD_WL_24           4'h7
`define IDD_WL_32           4'h8

// ----------------------------------------------------------------
// Frame-sync divider codes that change the loopback latency
// ----------------------------------------------------------------
`define IDD_FSYNC_DIV_0     3'h0
`define IDD_FSYNC_DIV_1     3'h1

// ----------------------------------------------------------------
// Pipeline depths in frames (zero frames before the first word)
// ----------------------------------------------------------------
`define IDD_TX_DLY_PACK     3'h5
`define IDD_TX_DLY_NOPACK   3'h3
`define IDD_RX_DLY_SHORT    3'h2
`define IDD_RX_DLY_LONG     3'h3
`define IDD_LB_DLY_8_DIV0   3'h6
`define IDD_LB_DLY_8        3'h5
`define IDD_LB_DLY_16_DIV1  3'h4
`define IDD_LB_DLY_16       3'h3
`define IDD_LB_DLY_WIDE     3'h3
`define IDD_LB_DLY_NOPACK   3'h2
`define IDD_PIPE_DEPTH      6
`define IDD_WORD_W          32

`endif

// ==== idd_buf2.v ====
`default_nettype none

// ----------------------------------------------------------------
// Two-entry buffer between the host and the transmitter
// ----------------------------------------------------------------
module idd_buf2 #(
  parameter WIDTH = 32
) (
  input  wire             sys_clk,   // System clock
  input  wire             resetn,    // Synchronous reset, active low
  input  wire             clkEn,     // Freezes state while low
  input  wire [WIDTH-1:0] inData,    // Word from the source
  input  wire             inValid,   // Source offers a word
  output wire             inReady,   // Buffer has room
  output wire [WIDTH-1:0] outData,   // Oldest word
  output wire             outValid,  // Buffer holds a word
  input  wire             outReady   // Sink takes the word
);

  reg [WIDTH-1:0] mem [0:1];
  reg             wrPtr_ff;
  reg             rdPtr_ff;
  reg [1:0]       count_ff;
  reg             inReady_ff;
  reg [1:0]       nxt_count;

  wire push = inValid & inReady_ff;
  wire pop  = outReady & (count_ff != 2'h0);

  // Occupancy after this cycle's push and pop
  always @* begin
    nxt_count = count_ff;
    if (push & ~pop) begin
      nxt_count = count_ff + 2'h1;
    end else if (pop & ~push) begin
      nxt_count = count_ff - 2'h1;
    end
  end

  // Ready is registered so the host sees a clean level
  always @(posedge sys_clk) begin
    if (!resetn) begin
      wrPtr_ff   <= 1'b0;
      rdPtr_ff   <= 1'b0;
      count_ff   <= 2'h0;
      inReady_ff <= 1'b0;
    end else if (clkEn) begin
      if (push) begin
        wrPtr_ff <= ~wrPtr_ff;
      end
      if (pop) begin
        rdPtr_ff <= ~rdPtr_ff;
      end
      count_ff   <= nxt_count;
      inReady_ff <= (nxt_count != 2'h2);
    end
  end

  // Storage needs no reset: nothing reads an empty slot
  always @(posedge sys_clk) begin
    if (clkEn && push) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  assign inReady  = inReady_ff;
  assign outValid = (count_ff != 2'h0);
  assign outData  = mem[rdPtr_ff];

endmodule // idd_buf2

`default_nettype wire

// ==== idd_core_props.sv ====
`include "idd_defs.vh"
`default_nettype none
// ----------------------------------------------------------
// Checker on the core ports
// ----------------------------------------------------------
module idd_core_props #(
  parameter WORD_W = 32
) (
  input wire logic              sys_clk,          // Clock
  input wire logic              resetn,           // Reset, low
  input wire logic              clkEn,            // Enable
  input wire logic              packEn,           // Packing
  input wire logic [3:0]        wordLen,          // Length code
  input wire logic [2:0]        frameSyncDivider, // Divider
  input wire logic              loopbackEn,       // Loopback
  input wire logic [WORD_W-1:0] txData,           // Tx word
  input wire logic              txValid,          // Tx offer
  input wire logic              txReady,          // Tx room
  input wire logic [WORD_W-1:0] rxData,           // Rx word
  input wire logic              rxValid,          // Rx strobe
  input wire logic              bitClk,           // Bit clock
  input wire logic              frameSync,        // Frame sync
  input wire logic              serialDataIn,     // Rx pin
  input wire logic              serialDataOut     // Tx pin
);
  // Takes with frame sync low, so no pop can sneak in between
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_take;
    clkEn && txValid && txReady && !frameSync;
  endsequence
  sequence s_two_takes;
    s_take ##1 s_take;
  endsequence

  AST_RST_OUT: assert property (disable iff (1'b0)
    !resetn |=> !txReady && !rxValid && rxData == '0 && !serialDataOut)
    else $error("outputs not cleared by reset");
  AST_TXREADY_RISE: assert property (
    $rose(resetn) && clkEn |=> txReady)
    else $error("txReady not raised after reset");
  AST_TX_FULL: assert property (
    s_two_takes |-> ##2 !txReady)
    else $error("txReady high with both entries filled");
  AST_RXVALID_PULSE: assert property (
    rxValid |=> !rxValid [*8])
    else $error("rxValid longer than one cycle");
  AST_RX_W8: assert property (
    rxValid && wordLen == `IDD_WL_8 |-> rxData[WORD_W-1:8] == '0)
    else $error("8-bit word has upper bits set");
  AST_RX_W16: assert property (
    rxValid && wordLen == `IDD_WL_16 |-> rxData[WORD_W-1:16] == '0)
    else $error("16-bit word has upper bits set");
  AST_RXDATA_HOLD: assert property (
    !rxValid |-> $stable(rxData))
    else $error("rxData moved without rxValid");
  AST_FREEZE: assert property (
    !clkEn |=> $stable(txReady) && $stable(rxValid) && $stable(serialDataOut))
    else $error("state moved while clkEn low");
endmodule // idd_core_props

bind idd_core idd_core_props #(.WORD_W(WORD_W)) u_props (
  .sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn), .packEn(packEn),
  .wordLen(wordLen), .frameSyncDivider(frameSyncDivider),
  .loopbackEn(loopbackEn), .txData(txData), .txValid(txValid),
  .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .bitClk(bitClk),
  .frameSync(frameSync), .serialDataIn(serialDataIn),
  .serialDataOut(serialDataOut));
`default_nettype wire

// ==== idd_codec_model.sv ====
`default_nettype none
// ----------------------------------------------------------
// Far-end codec: framer, talker and listener
// ----------------------------------------------------------
module idd_codec_model (
  input  wire logic       run,           // Frames run while high
  input  wire logic [5:0] wordBits,      // Word length in bits
  input  wire logic       serialDataOut, // From the core
  output var  logic       bitClk,        // Bit clock
  output var  logic       frameSync,     // Frame sync
  output var  logic       serialDataIn,  // To the core
  output var  logic [7:0] frameCnt       // Frames since start
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FRAME_BITS = 34;
  logic [31:0] capWord [0:15];
  logic [31:0] sendW;
  logic [31:0] cap;

  // Words sent; never zero, so a lost frame cannot pass
  function automatic logic [31:0] frame_word(input int n, input int wb);
    return (32'h5a3c96a0 | n) & (32'hffffffff >> (32 - wb));
  endfunction

  // Clock stands still between bursts; outside the word bits the data line
  // never keeps its last bit, so a late sample cannot pass by chance
  initial begin
    bitClk = 1'b0;
    frameSync = 1'b0;
    serialDataIn = 1'b0;
    frameCnt = 8'h00;
    #7;
    forever begin
      if (!run) begin
        frameCnt = 8'h00;
        serialDataIn = ~serialDataIn;
        #80;
      end else begin
        frameCnt = frameCnt + 8'h01;
        sendW = frame_word(frameCnt, wordBits);
        cap = '0;
        frameSync = 1'b1;
        #80;
        for (int b = 0; b < FRAME_BITS; b++) begin
          bitClk = 1'b1;
          #70;
          if (b >= 1 && b <= wordBits) cap = {cap[30:0], serialDataOut};
          #10;
          bitClk = 1'b0;
          frameSync = (b + 1 < FRAME_BITS / 2);
          serialDataIn = (b < wordBits) ? sendW[wordBits - 1 - b]
                                        : ~serialDataIn;
          if (b < FRAME_BITS - 1) #80;
        end
        // Leading zero frames are kept as well, for the bench to judge
        if (frameCnt < 16) capWord[frameCnt] = cap;
      end
    end
  end
endmodule // idd_codec_model
`default_nettype wire

// ==== test_i2s_internal_data_delay.sv ====
`include "idd_defs.vh"
`default_nettype none
// ----------------------------------------------------------
// Bench for the latency pipelines
// ----------------------------------------------------------
module test_i2s_internal_data_delay;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        clkEn = 1'b1;
  logic        packEn = 1'b0;
  logic [3:0]  wordLen = 4'h0;
  logic [2:0]  frameSyncDivider = 3'h0;
  logic        loopbackEn = 1'b0;
  logic [31:0] txData = 32'h0;
  logic        txValid = 1'b0;
  logic        run = 1'b0;
  logic [5:0]  wordBits = 6'h08;
  logic        txReady, rxValid, bitClk, frameSync;
  logic        serialDataIn, serialDataOut;
  logic [31:0] rxData;
  logic [7:0]  frameCnt;
  logic [31:0] samp [0:15];
  int          nSamp, err_count, n_checks;

  always #10 sys_clk = ~sys_clk;

  idd_core dut (
    .sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn), .packEn(packEn),
    .wordLen(wordLen), .frameSyncDivider(frameSyncDivider),
    .loopbackEn(loopbackEn), .txData(txData), .txValid(txValid),
    .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .bitClk(bitClk),
    .frameSync(frameSync), .serialDataIn(serialDataIn),
    .serialDataOut(serialDataOut));
  idd_codec_model u_codec (
    .run(run), .wordBits(wordBits), .serialDataOut(serialDataOut),
    .bitClk(bitClk), .frameSync(frameSync), .serialDataIn(serialDataIn),
    .frameCnt(frameCnt));

  // Log each received word; the strobe lasts a single cycle
  always @(posedge sys_clk) begin
    if (!resetn) nSamp <= 0;
    else if (rxValid === 1'b1) begin
      if (nSamp < 16) samp[nSamp] <= rxData;
      nSamp <= nSamp + 1;
    end
  end

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Bounded wait on frames sent or words received
  task automatic wait_for(input int n, input bit onRx);
    for (int i = 0; i < 400 * n && (onRx ? nSamp : frameCnt) < n; i++) tick();
    if ((onRx ? nSamp : frameCnt) < n) begin
      $display("CHECK FAILED wait expected %0d seen timeout", n);
      err_count++;
      report_and_stop();
    end
  endtask

  // Stop the codec, freeze a while, then reset with new settings
  task automatic setup(input bit pk, input logic [3:0] wl, input int wb,
                       input logic [2:0] div, input bit lb);
    run = 1'b0;
    for (int i = 0; i < 400 && frameCnt != 0; i++) tick();
    if (frameCnt != 0) begin
      $display("CHECK FAILED codec stop expected 0 seen %0d", frameCnt);
      err_count++;
      report_and_stop();
    end
    clkEn = 1'b0;
    repeat (4) tick();
    clkEn = 1'b1;
    resetn = 1'b0;
    packEn = pk;
    wordLen = wl;
    wordBits = 6'(wb);
    frameSyncDivider = div;
    loopbackEn = lb;
    repeat (16) tick();
    resetn = 1'b1;
    repeat (2) tick();
  endtask

  // Held until an edge finds room; the caller drops txValid
  task automatic push(input logic [31:0] w);
    int i;
    txData = w;
    txValid = 1'b1;
    for (i = 0; i < 400 && txReady !== 1'b1; i++) tick();
    if (txReady !== 1'b1) begin
      $display("CHECK FAILED txReady expected 1 seen %b", txReady);
      err_count++;
      report_and_stop();
    end
    tick();
  endtask

  // Two words into a stalled link, a third once one has left
  task automatic test_tx(input bit pk, input int dly);
    logic [31:0] exp;
    setup(pk, `IDD_WL_8, 8, 3'h0, 1'b0);
    push(32'hc3);
    push(32'h5a);
    txValid = 1'b0;
    tick();
    check("buffer full", 32'h0, {31'h0, txReady});
    run = 1'b1;
    push(32'h81);
    txValid = 1'b0;
    wait_for(dly + 5, 1'b0);
    for (int k = 1; k <= dly + 4; k++) begin
      exp = k == dly + 1 ? 32'hc3 : k == dly + 2 ? 32'h5a :
            k == dly + 3 ? 32'h81 : 32'h0;
      check("tx frame", exp, u_codec.capWord[k]);
    end
    $display("tx test pack %0d done", pk);
  endtask

  // Zero samples first, then the codec's or the host's first word
  task automatic test_rx(input bit pk, input logic [3:0] wl, input int wb,
                         input logic [2:0] div, input bit lb, input int n);
    logic [31:0] exp;
    setup(pk, wl, wb, div, lb);
    if (lb) push(u_codec.frame_word(9, wb));
    txValid = 1'b0;
    run = 1'b1;
    wait_for(n, 1'b1);
    for (int k = 1; k <= n; k++) begin
      exp = k < n ? 32'h0 : u_codec.frame_word(lb ? 9 : 1, wb);
      check("rx sample", exp, samp[k - 1]);
    end
    $display("rx test loop %0d width %0d div %0d done", lb, wb, div);
  endtask

  // Main sequence
  initial begin
    test_tx(1'b1, 5);
    test_tx(1'b0, 3);
    test_rx(1'b0, `IDD_WL_8, 8, 3'h0, 1'b0, 3);
    test_rx(1'b0, `IDD_WL_16, 16, 3'h0, 1'b0, 4);
    test_rx(1'b0, `IDD_WL_12, 12, 3'h0, 1'b0, 4);
    test_rx(1'b0, `IDD_WL_32, 32, 3'h0, 1'b0, 3);
    test_rx(1'b1, `IDD_WL_8, 8, 3'h0, 1'b1, 7);
    test_rx(1'b1, `IDD_WL_8, 8, 3'h5, 1'b1, 6);
    test_rx(1'b1, `IDD_WL_14, 14, 3'h1, 1'b1, 5);
    test_rx(1'b1, `IDD_WL_10, 10, 3'h2, 1'b1, 4);
    test_rx(1'b1, `IDD_WL_16, 16, 3'h5, 1'b1, 4);
    test_rx(1'b0, `IDD_WL_24, 24, 3'h3, 1'b1, 3);
    report_and_stop();
  end
endmodule // test_i2s_internal_data_delay
`default_nettype wire
